// ===== pkg/utx_pkg.sv
// Constants, register map and types of the UART transmitter with fractional baud generator.
// Assumes one clock, the baud source clock, which clocks the whole block.
package utx_pkg;
	// Register byte offsets on the APB port.
	localparam logic [7:0]  UTX_OFF_CTRL       = 8'h00;
	localparam logic [7:0]  UTX_OFF_BAUD       = 8'h04;
	localparam logic [7:0]  UTX_OFF_TXBUF      = 8'h08;
	localparam logic [7:0]  UTX_OFF_STATUS     = 8'h0c;
	localparam logic [7:0]  UTX_OFF_COUNT      = 8'h10;
	// Control fields.
	localparam int          UTX_CTRL_HOLD_BIT  = 0;
	localparam int          UTX_CTRL_OS_BIT    = 1;
	localparam logic [1:0]  UTX_CTRL_RESET     = 2'h1;
	// Baud fields.
	localparam int          UTX_PRESCALE_LSB   = 0;
	localparam int          UTX_PRESCALE_MSB   = 15;
	localparam int          UTX_FIRST_LSB      = 16;
	localparam int          UTX_FIRST_MSB      = 19;
	localparam int          UTX_SECOND_LSB     = 24;
	localparam int          UTX_SECOND_MSB     = 31;
	localparam logic [15:0] UTX_PRESCALE_RESET = 16'h0003;
	localparam logic [3:0]  UTX_FIRST_RESET    = 4'h0;
	localparam logic [7:0]  UTX_SECOND_RESET   = 8'h00;
	// Status fields.
	localparam int          UTX_ST_EMPTY_BIT   = 0;
	localparam int          UTX_ST_BUSY_BIT    = 1;
	localparam int          UTX_ST_GEN_BIT     = 2;
	localparam int          UTX_ST_VOTE_BIT    = 3;
	// Frame: start bit, eight data bits LSB first, one stop bit.
	localparam logic [3:0]  UTX_FRAME_LAST     = 4'h9;
	localparam logic [7:0]  UTX_TXBUF_RESET    = 8'h00;
	localparam logic [9:0]  UTX_LINE_IDLE      = 10'h3ff;
	// Baud generator limits and positions.
	localparam logic [15:0] UTX_LF_MIN_DIV     = 16'h0003;
	localparam logic [15:0] UTX_OS_MIN_DIV     = 16'h0001;
	localparam logic [3:0]  UTX_POS_LAST       = 4'hf;
	localparam logic [2:0]  UTX_PAT_LAST       = 3'h7;
	localparam logic [3:0]  UTX_OS_SAMPLE_0    = 4'h6;
	localparam logic [3:0]  UTX_OS_SAMPLE_1    = 4'h7;
	localparam logic [3:0]  UTX_OS_SAMPLE_2    = 4'h8;
	localparam logic [4:0]  UTX_SIXTEEN        = 5'h10;

	typedef enum logic [1:0] {
		UTX_ST_IDLE,
		UTX_ST_WAIT,
		UTX_ST_SEND
	} utx_state_t;
endpackage

// ===== hdl/utx_vote.sv
// Three-sample majority voter on the serial line.
// Assumes the line input is already synchronous to the clock.
module utx_vote
	import utx_pkg::*;
(
	// Clock and reset.
	input  wire logic core_clk_in,
	input  wire logic reset_n_in,
	// Strobes from the baud generator.
	input  wire logic sample_in,
	input  wire logic bit_end_in,
	// Line and result.
	input  wire logic line_in,
	output logic      vote_out,
	output logic      vote_valid_out
);
	logic [2:0] samples;

	function automatic logic majority(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			samples <= 3'h7;
		end else if (sample_in) begin
			samples <= {samples[1:0], line_in};
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			vote_out       <= 1'b1;
			vote_valid_out <= 1'b0;
		end else begin
			vote_valid_out <= bit_end_in;
			if (bit_end_in) begin
				// Short bits put the third sample in the bit-end cycle, so it is counted here as well.
				vote_out <= majority(sample_in ? {samples[1:0], line_in} : samples); // [RULE_09] [RULE_15]
			end
		end
	end
endmodule

// ===== hdl/utx_baud_gen.sv
// Fractional baud generator: low-frequency and sixteen-times oversampling modes.
// Assumes the enable stays low while idle and restart is given in the cycle of the bit tick.
module utx_baud_gen
	import utx_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	// Control.
	input  wire logic        enable_in,
	input  wire logic        restart_in,
	input  wire logic        oversample_in,
	input  wire logic [15:0] prescale_in,
	input  wire logic [3:0]  first_in,
	input  wire logic [7:0]  second_in,
	// Ticks and sample strobes.
	output logic             bit_tick_out,
	output logic             sixteenth_tick_out,
	output logic             sample_out
);
	logic [16:0] cnt;
	logic [3:0]  pos;
	logic [2:0]  idx;
	logic [15:0] div;
	logic        m_cur;
	logic        f_cur;
	logic [16:0] len;
	logic [16:0] limit;
	logic [16:0] half;
	logic        sub_end;

	function automatic logic first_stage_bit(input logic [3:0] pat, input logic [3:0] p);
		logic [4:0] low;
		logic [4:0] high;
		low  = ({1'b0, pat} + 5'h01) >> 1;
		high = {1'b0, pat} >> 1;
		return (p != 4'h0) && (({1'b0, p} <= low) || ({1'b0, p} >= (UTX_SIXTEEN - high)));
	endfunction

	// Prescalers below the mode limits are clamped so the rate never exceeds the supported maximum.
	assign div   = oversample_in ? ((prescale_in < UTX_OS_MIN_DIV) ? UTX_OS_MIN_DIV : prescale_in) // [RULE_14]
	                             : ((prescale_in < UTX_LF_MIN_DIV) ? UTX_LF_MIN_DIV : prescale_in); // [RULE_08]
	assign m_cur = second_in[UTX_PAT_LAST - idx]; // [RULE_12]
	assign f_cur = first_stage_bit(first_in, pos); // [RULE_16] [RULE_17]
	assign len   = oversample_in ? ({1'b0, div} + {16'h0, f_cur} + {16'h0, m_cur & (pos == UTX_POS_LAST)}) // [RULE_13] [RULE_18]
	                             : ({1'b0, div} + {16'h0, m_cur}); // [RULE_06] [RULE_10]
	assign limit = len - 17'h00001; // [RULE_22]
	assign half  = len >> 1;
	assign sub_end = enable_in && (cnt == limit);
	assign bit_tick_out       = sub_end && (!oversample_in || pos == UTX_POS_LAST); // [RULE_07]
	assign sixteenth_tick_out = sub_end && oversample_in;
	assign sample_out = enable_in && (oversample_in
		? (sub_end && (pos == UTX_OS_SAMPLE_0 || pos == UTX_OS_SAMPLE_1 || pos == UTX_OS_SAMPLE_2)) // [RULE_15]
		: (cnt == half - 17'h00001 || cnt == half || cnt == half + 17'h00001)); // [RULE_09]

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt <= 17'h00000;
			pos <= 4'h0;
			idx <= 3'h0;
		end else if (!enable_in) begin
			cnt <= 17'h00000; // [RULE_02]
			pos <= 4'h0;
			idx <= 3'h0;
		end else if (sub_end) begin
			cnt <= 17'h00000; // [RULE_22]
			if (bit_tick_out) begin
				pos <= 4'h0; // [RULE_16]
				idx <= restart_in ? 3'h0 : idx + 3'h1; // [RULE_11]
			end else begin
				pos <= pos + 4'h1;
			end
		end else begin
			cnt <= cnt + 17'h00001;
		end
	end
endmodule

// ===== hdl/utx_top.sv
// UART transmitter with fractional baud generator and its APB register file.
// Assumes a zero-wait APB master on the baud source clock and an idle-high transmit line.
//
// What this block does
// [RULE_01] Releasing soft reset hold leaves the transmitter idle and ready for a character.
// [RULE_02] While idle the baud generator stays stopped and produces no ticks.
// [RULE_03] Buffer write starts generator; character loads into shifter on next bit tick.
// [RULE_04] Buffer empty flag is set whenever the buffer can take a character.
// [RULE_05] A waiting character follows back to back; otherwise return idle, stop generator.
// [RULE_06] Oversample select 0 gives low-frequency mode: prescaler plus one modulator.
// [RULE_07] Oversample select 1 derives bit tick from a sixteen-times faster tick.
// [RULE_08] Low-frequency mode bit rate is at most a third of the source clock.
// [RULE_09] Low-frequency bits are voted from three samples around the bit middle.
// [RULE_10] Bit lasts prescaler clocks plus one when its second-stage pattern bit is set.
// [RULE_11] Second-stage pattern walks eight positions, wraps, restarts at each start bit.
// [RULE_12] Start bit uses the pattern MSB, later bits the lower bits in turn.
// [RULE_13] Oversampling: prescaler and first modulator make sixteenth ticks, divide by sixteen.
// [RULE_14] Oversampling mode bit rate is at most a sixteenth of the source clock.
// [RULE_15] Oversampling votes are one sixteenth of a bit apart.
// [RULE_16] First-stage pattern lengthens a sixteenth period by one clock, restarting each bit.
// [RULE_17] First-stage pattern indexed by sixteenth count; position zero never lengthened.
// [RULE_18] Oversampling bit tick is also modulated by the second-stage pattern.
// [RULE_19] Software picks oversampling for divisors of sixteen or more.
// [RULE_20] Low-frequency software sets prescaler to integer part, fraction via modulator.
// [RULE_21] Software may look up the second-stage pattern from the fractional divisor.
// [RULE_22] Bit length counts are reloaded at each boundary without lost or extra clocks.
module utx_top
	import utx_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        reset_n_in,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Serial line.
	input  wire logic        rx_line_in,
	output logic             tx_line_out,
	// Status outputs.
	output logic             tx_buffer_empty_flag_out,
	output logic             bit_tick_out,
	output logic             sixteenth_bit_tick_out,
	output logic             busy_out
);
	logic        soft_reset_hold;
	logic        oversample_select;
	logic [15:0] prescale_divisor;
	logic [3:0]  first_stage_pattern;
	logic [7:0]  second_stage_pattern;
	logic [7:0]  tx_buffer;
	logic        tx_buffer_full;
	logic [9:0]  shifter;
	logic [3:0]  bits_left;
	logic [15:0] char_count;
	utx_state_t  state;
	logic        setup;
	logic        wr;
	logic        wr_ctrl;
	logic        wr_baud;
	logic        wr_txbuf;
	logic        gen_enable;
	logic        bit_tick;
	logic        restart;
	logic        load;
	logic        finish;
	logic        sample;
	logic        vote;
	logic        vote_valid;

	function automatic logic mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == UTX_OFF_CTRL) begin
			hit = 1'b1;
		end else if (a == UTX_OFF_BAUD) begin
			hit = 1'b1;
		end else if (a == UTX_OFF_TXBUF) begin
			hit = 1'b1;
		end else if (a == UTX_OFF_STATUS) begin
			hit = 1'b1;
		end else if (a == UTX_OFF_COUNT) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// Zero-wait slave: the access phase always completes in its first cycle.
	assign pready_out = 1'b1;
	assign setup      = psel_in && !penable_in;
	assign wr         = psel_in && penable_in && pwrite_in;
	assign wr_ctrl    = wr && (paddr_in == UTX_OFF_CTRL);
	assign wr_baud    = wr && (paddr_in == UTX_OFF_BAUD);
	assign wr_txbuf   = wr && (paddr_in == UTX_OFF_TXBUF) && !soft_reset_hold;

	assign gen_enable = (state != UTX_ST_IDLE); // [RULE_02] [RULE_03]
	assign load       = bit_tick && (state == UTX_ST_WAIT); // [RULE_03]
	assign finish     = bit_tick && (state == UTX_ST_SEND) && (bits_left == 4'h0);
	assign restart    = load || (finish && tx_buffer_full); // [RULE_05] [RULE_11]

	assign tx_line_out              = shifter[0];
	assign tx_buffer_empty_flag_out = !tx_buffer_full && !soft_reset_hold; // [RULE_04]
	assign bit_tick_out             = bit_tick;
	assign busy_out                 = (state == UTX_ST_SEND);

	utx_baud_gen u_baud (
		.core_clk_in        (core_clk_in),
		.reset_n_in         (reset_n_in),
		.enable_in          (gen_enable),
		.restart_in         (restart),
		.oversample_in      (oversample_select),
		.prescale_in        (prescale_divisor),
		.first_in           (first_stage_pattern),
		.second_in          (second_stage_pattern),
		.bit_tick_out       (bit_tick),
		.sixteenth_tick_out (sixteenth_bit_tick_out),
		.sample_out         (sample)
	);

	utx_vote u_vote (
		.core_clk_in    (core_clk_in),
		.reset_n_in     (reset_n_in),
		.sample_in      (sample),
		.bit_end_in     (bit_tick),
		.line_in        (rx_line_in),
		.vote_out       (vote),
		.vote_valid_out (vote_valid)
	);

	// Control register.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			soft_reset_hold   <= UTX_CTRL_RESET[UTX_CTRL_HOLD_BIT];
			oversample_select <= UTX_CTRL_RESET[UTX_CTRL_OS_BIT];
		end else if (wr_ctrl) begin
			soft_reset_hold   <= pwdata_in[UTX_CTRL_HOLD_BIT];
			oversample_select <= pwdata_in[UTX_CTRL_OS_BIT]; // [RULE_06] [RULE_07]
		end
	end

	// Baud register; changing it mid-character takes effect on the running bit.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prescale_divisor     <= UTX_PRESCALE_RESET;
			first_stage_pattern  <= UTX_FIRST_RESET;
			second_stage_pattern <= UTX_SECOND_RESET;
		end else if (wr_baud) begin
			prescale_divisor     <= pwdata_in[UTX_PRESCALE_MSB:UTX_PRESCALE_LSB];
			first_stage_pattern  <= pwdata_in[UTX_FIRST_MSB:UTX_FIRST_LSB];
			second_stage_pattern <= pwdata_in[UTX_SECOND_MSB:UTX_SECOND_LSB];
		end
	end

	// Transmit buffer. A write in the cycle of a load wins, so no character is lost.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_buffer      <= UTX_TXBUF_RESET;
			tx_buffer_full <= 1'b0;
		end else if (soft_reset_hold) begin
			tx_buffer_full <= 1'b0;
		end else if (wr_txbuf) begin
			tx_buffer      <= pwdata_in[7:0];
			tx_buffer_full <= 1'b1; // [RULE_03]
		end else if (restart) begin
			tx_buffer_full <= 1'b0; // [RULE_04]
		end
	end

	// Transmit sequencer.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= UTX_ST_IDLE;
		end else if (soft_reset_hold) begin
			state <= UTX_ST_IDLE; // [RULE_01]
		end else begin
			case (state)
				UTX_ST_IDLE: begin
					if (tx_buffer_full) begin
						state <= UTX_ST_WAIT; // [RULE_03]
					end
				end
				UTX_ST_WAIT: begin
					if (load) begin
						state <= UTX_ST_SEND;
					end
				end
				UTX_ST_SEND: begin
					if (finish && !tx_buffer_full) begin
						state <= UTX_ST_IDLE; // [RULE_05]
					end
				end
				default: begin
					state <= UTX_ST_IDLE;
				end
			endcase
		end
	end

	// Shift register: line idles high, frame is start, data LSB first, stop.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shifter   <= UTX_LINE_IDLE;
			bits_left <= 4'h0;
		end else if (soft_reset_hold) begin
			shifter   <= UTX_LINE_IDLE; // [RULE_01]
			bits_left <= 4'h0;
		end else if (restart) begin
			shifter   <= {1'b1, tx_buffer, 1'b0}; // [RULE_03] [RULE_05]
			bits_left <= UTX_FRAME_LAST;
		end else if (finish) begin
			shifter   <= UTX_LINE_IDLE;
		end else if (bit_tick && state == UTX_ST_SEND) begin
			shifter   <= {1'b1, shifter[9:1]};
			bits_left <= bits_left - 4'h1;
		end
	end

	// Count of characters started, for software progress checks.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			char_count <= 16'h0000;
		end else if (soft_reset_hold) begin
			char_count <= 16'h0000;
		end else if (restart) begin
			char_count <= char_count + 16'h0001;
		end
	end

	// Read data and error are captured in the setup cycle and stand through the access cycle.
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_out  <= 32'h00000000;
			pslverr_out <= 1'b0;
		end else if (setup) begin
			pslverr_out <= !mapped(paddr_in);
			prdata_out  <= 32'h00000000;
			if (!pwrite_in) begin
				if (paddr_in == UTX_OFF_CTRL) begin
					prdata_out[UTX_CTRL_HOLD_BIT] <= soft_reset_hold;
					prdata_out[UTX_CTRL_OS_BIT]   <= oversample_select;
				end else if (paddr_in == UTX_OFF_BAUD) begin
					prdata_out[UTX_PRESCALE_MSB:UTX_PRESCALE_LSB] <= prescale_divisor;
					prdata_out[UTX_FIRST_MSB:UTX_FIRST_LSB]       <= first_stage_pattern;
					prdata_out[UTX_SECOND_MSB:UTX_SECOND_LSB]     <= second_stage_pattern;
				end else if (paddr_in == UTX_OFF_TXBUF) begin
					prdata_out[7:0] <= tx_buffer;
				end else if (paddr_in == UTX_OFF_STATUS) begin
					prdata_out[UTX_ST_EMPTY_BIT] <= tx_buffer_empty_flag_out;
					prdata_out[UTX_ST_BUSY_BIT]  <= busy_out;
					prdata_out[UTX_ST_GEN_BIT]   <= gen_enable;
					prdata_out[UTX_ST_VOTE_BIT]  <= vote;
				end else if (paddr_in == UTX_OFF_COUNT) begin
					prdata_out[15:0] <= char_count;
				end
			end
		end else if (!psel_in) begin
			pslverr_out <= 1'b0;
		end
	end

	// The voted line value is only observed through the status register.
	logic unused_vote_valid;
	assign unused_vote_valid = vote_valid;
endmodule

// ===== tb/utx_top_assertions.sv
// Port-level checks for the transmitter: APB answers, idle quiet, frame start and end.
// Assumes a single clock domain; bound to the top module below.
module utx_top_assertions
	import utx_pkg::*;
(
	// Clock and reset.
	input wire logic       core_clk_in,
	input wire logic       reset_n_in,
	// APB.
	input wire logic       psel_in,
	input wire logic       penable_in,
	input wire logic       pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic       pready_out,
	input wire logic       pslverr_out,
	// Line and status.
	input wire logic       tx_line_out,
	input wire logic       tx_buffer_empty_flag_out,
	input wire logic       bit_tick_out,
	input wire logic       sixteenth_bit_tick_out,
	input wire logic       busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	property p_ready;
		psel_in |-> pready_out;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in a transfer");
	property p_unmapped;
		psel_in && penable_in && paddr_in > UTX_OFF_COUNT |-> pslverr_out;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
	property p_err_clear;
		!psel_in |=> !pslverr_out;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error response outlived the transfer");
	property p_idle_quiet;
		!busy_out && tx_buffer_empty_flag_out |-> !bit_tick_out && !sixteenth_bit_tick_out;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("tick while idle");
	property p_idle_high;
		!busy_out |-> tx_line_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low outside a frame");
	property p_load_start;
		$rose(busy_out) |-> $past(bit_tick_out) && !tx_line_out;
	endproperty
	a_load_start: assert property (p_load_start) else $error("frame did not start on a tick");
	property p_write_flag;
		psel_in && penable_in && pwrite_in && paddr_in == UTX_OFF_TXBUF && tx_buffer_empty_flag_out
			|=> !tx_buffer_empty_flag_out;
	endproperty
	a_write_flag: assert property (p_write_flag) else $error("empty flag kept after write");
	property p_min_spacing;
		bit_tick_out |=> !bit_tick_out [*2];
	endproperty
	a_min_spacing: assert property (p_min_spacing) else $error("bit ticks too close");
	property p_stop_end;
		$fell(busy_out) |-> $past(bit_tick_out) && tx_line_out && tx_buffer_empty_flag_out;
	endproperty
	a_stop_end: assert property (p_stop_end) else $error("frame ended off a tick");
endmodule

bind utx_top utx_top_assertions u_chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .tx_line_out(tx_line_out),
	.tx_buffer_empty_flag_out(tx_buffer_empty_flag_out), .bit_tick_out(bit_tick_out),
	.sixteenth_bit_tick_out(sixteenth_bit_tick_out), .busy_out(busy_out));

// ===== tb/utx_remote_rx.sv
// Remote receiver on the transmit line; its line back loops the transmit line inverted for the voter.
// Assumes the bench gives the nominal bit length in clocks; every line edge re-aligns the phase.
module utx_remote_rx (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       line_in,
	input  int              bit_len_in,
	output logic            rx_line_out,
	output logic [7:0]      byte_out,
	output int              count_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev;
	logic       active;
	logic [9:0] sh;
	int         phase;
	int         idx;
	// Inverting the echo makes the last vote of a frame low, which a stuck voter cannot fake.
	assign rx_line_out = ~line_in;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= 1'b1;
			active <= 1'b0;
			sh <= 10'h000;
			phase <= 0;
			idx <= 0;
			byte_out <= 8'h00;
			count_out <= 0;
		end else begin
			prev <= line_in;
			if (!active) begin
				if (prev && !line_in) begin
					active <= 1'b1;
					phase <= 1;
					idx <= 0;
				end
			end else if (line_in != prev) begin
				phase <= 1;
			end else if (phase == bit_len_in / 2) begin
				sh[idx] <= line_in;
				phase <= phase + 1 - bit_len_in;
				idx <= idx + 1;
				// A low stop bit drops the character, as a real receiver would.
				if (idx == 9) begin
					active <= 1'b0;
					if (line_in) begin
						byte_out <= sh[8:1];
						count_out <= count_out + 1;
					end
				end
			end else begin
				phase <= phase + 1;
			end
		end
	end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the transmitter with fractional baud generator.
// Assumes the register map of the package and a remote receiver on the line.
module tb;
	import utx_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_n, psel, pen, pwr, pready, pslverr, rxl, txl, flag, tick, tick16, busy;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  rbyte;
	int          bit_len, rcnt, mismatches, check_count;
	utx_top u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .rx_line_in(rxl), .tx_line_out(txl), .tx_buffer_empty_flag_out(flag),
		.bit_tick_out(tick), .sixteenth_bit_tick_out(tick16), .busy_out(busy));
	utx_remote_rx u_rx (.clk_in(clk), .rst_n_in(rst_n), .line_in(txl), .bit_len_in(bit_len),
		.rx_line_out(rxl), .byte_out(rbyte), .count_out(rcnt));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r & mask);
	endtask
	task automatic wait_tick();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 2000);
		chk("first bit tick", 32'h1, {31'h0, tick});
	endtask
	// Measures the ten bit periods of one frame, starting just after a bit tick.
	task automatic frame(input int pre, input logic os, input logic [3:0] f, input logic [7:0] s);
		int len;
		int n16;
		for (int i = 0; i < 10; i++) begin
			len = 0;
			n16 = 0;
			do begin
				@(negedge clk);
				len++;
				n16 += int'(tick16 === 1'b1);
			end while (tick !== 1'b1 && len < 1000);
			chk("bit length", os ? 16 * pre + f + s[7 - i % 8] : pre + s[7 - i % 8], len);
			chk("bit length", os ? 16 * pre + f + s[7 - i % 8] : pre + s[7 - i % 8], len);
			chk("bit length", os ? 16 * pre + f + s[7 - i % 8] : pre + s[7 - i % 8], len);
			chk("sixteenths per bit", os ? 16 : 0, n16);
		end
	endtask
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		rd(UTX_OFF_CTRL, 32'hffffffff, 32'h1, "ctrl reset");
		rd(UTX_OFF_BAUD, 32'hffffffff, 32'h3, "baud reset");
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		wr(UTX_OFF_TXBUF, 32'h55);
		repeat (20) @(posedge clk);
		chk("busy under hold", 32'h0, {31'h0, busy});
		wr(UTX_OFF_CTRL, 32'h0);
		rd(UTX_OFF_STATUS, 32'h7, 32'h1, "idle status");
		rd(UTX_OFF_COUNT, 32'hffffffff, 32'h0, "count after hold");
		$display("test reset done");
	endtask
	task automatic t_lf();
		bit_len = 4;
		wr(UTX_OFF_BAUD, 32'h35000004);
		wr(UTX_OFF_TXBUF, 32'h55);
		wait_tick();
		fork
			frame(4, 1'b0, 4'h0, 8'h35);
			wr(UTX_OFF_TXBUF, 32'h56);
		join
		frame(4, 1'b0, 4'h0, 8'h35);
		@(negedge clk);
		chk("busy after last", 32'h0, {31'h0, busy});
		chk("received count", 32'h2, rcnt);
		chk("received byte", 32'h56, {24'h0, rbyte});
		rd(UTX_OFF_COUNT, 32'hffffffff, 32'h2, "chars started");
		// The looped-back line is inverted, so the stop bit votes low.
		rd(UTX_OFF_STATUS, 32'hf, 32'h1, "status after frames");
		$display("test low frequency done");
	endtask
	task automatic t_os();
		logic [3:0] f;
		logic [7:0] s;
		for (int k = 0; k < 2; k++) begin
			f = k == 0 ? 4'h2 : 4'hf;
			s = k == 0 ? 8'h01 : 8'h80;
			bit_len = 16 + f;
			wr(UTX_OFF_CTRL, 32'h2);
			wr(UTX_OFF_BAUD, {s, 4'h0, f, 16'h0001});
			wr(UTX_OFF_TXBUF, 32'h55);
			wait_tick();
			frame(1, 1'b1, f, s);
			@(negedge clk);
			chk("os busy after frame", 32'h0, {31'h0, busy});
			chk("os received byte", 32'h55, {24'h0, rbyte});
			chk("os received count", 3 + k, rcnt);
		end
		rd(UTX_OFF_STATUS, 32'hf, 32'h1, "os vote");
		$display("test oversampling done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bit_len = 4;
		mismatches = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_lf();
		t_os();
		conclude();
	end
endmodule
